// >>> dce_regs.svh
/*
 Register map, field positions, reset values and APB answer constants
 for the channel event control block.
 Assumes a 32-bit APB data path and byte addresses.
*/
`ifndef DCE_REGS_SVH
`define DCE_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DCE_OFS_CTRL 12'h000
`define DCE_OFS_STAT 12'h004
`define DCE_OFS_ECON 12'h008
`define DCE_OFS_SSIZ 12'h00C
`define DCE_OFS_DSIZ 12'h010

// ----------------------------------------
// Event control fields
// ----------------------------------------
`define DCE_ABORT_SEL_HI 23
`define DCE_ABORT_SEL_LO 16
`define DCE_START_SEL_HI 15
`define DCE_START_SEL_LO 8
`define DCE_FORCE_BIT 7
`define DCE_SWABORT_BIT 6
`define DCE_PATTERN_ABORT_ENABLE_BIT 5
`define DCE_STARTEN_BIT 4
`define DCE_ABORTEN_BIT 3
`define DCE_ECON_RESET 32'h00FF_FF00
`define DCE_SEL_RESET 8'hFF

// ----------------------------------------
// Control, status and size fields
// ----------------------------------------
`define DCE_CHON_BIT 0
`define DCE_ACTIVE_BIT 1
`define DCE_AFLAG_BIT 0
`define DCE_SIZE_HI 15
`define DCE_SIZE_RESET 16'h0000
`define DCE_ZERO32 32'h0000_0000

`endif

// >>> dce_pkg.sv
/*
 Types shared by the channel event control design.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package dce_pkg;
   // ----------------------------------------
   // Channel transfer state, Gray coded
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      DCE_IDLE = 2'h0,
      DCE_ACTIVE = 2'h1
   } dce_state_t;

   // ----------------------------------------
   // Register selector
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      DCE_REG_NONE = 3'h0,
      DCE_REG_CTRL = 3'h1,
      DCE_REG_STAT = 3'h2,
      DCE_REG_ECON = 3'h3,
      DCE_REG_SSIZ = 3'h4,
      DCE_REG_DSIZ = 3'h5
   } dce_reg_t;
endpackage

`default_nettype wire

// >>> dce_apb_slave.sv
/*
 APB slave front end: address decode, write strobe, registered read data
 and error answer for unmapped addresses.
 Assumes an APB master in the same clock domain; answers with no wait.
*/
`include "dce_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dce_apb_slave
#(
   parameter int ADDR_W = 12
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   output var logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Register side
   input wire logic [31:0] read_word,
   output dce_pkg::dce_reg_t reg_sel,
   output logic write_strobe
);
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire logic [11:0] offset = 12'(paddr);
   wire logic setup_phase = psel & ~penable;
   wire logic mapped = (reg_sel != dce_pkg::DCE_REG_NONE);

   // Offset to register selector
   assign reg_sel =
      (offset == `DCE_OFS_CTRL) ? dce_pkg::DCE_REG_CTRL :
      (offset == `DCE_OFS_STAT) ? dce_pkg::DCE_REG_STAT :
      (offset == `DCE_OFS_ECON) ? dce_pkg::DCE_REG_ECON :
      (offset == `DCE_OFS_SSIZ) ? dce_pkg::DCE_REG_SSIZ :
      (offset == `DCE_OFS_DSIZ) ? dce_pkg::DCE_REG_DSIZ :
      dce_pkg::DCE_REG_NONE;

   // Zero wait answer, error on unmapped
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign write_strobe = psel & penable & pwrite & mapped;

   // Read data captured in setup phase
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         prdata <= `DCE_ZERO32;
      else if (setup_phase)
         prdata <= (mapped & ~pwrite) ? read_word : `DCE_ZERO32;
   end

   // Elaboration check on address width
   if (ADDR_W < 5) begin : g_bad_addr
      $error("dce_apb_slave: ADDR_W too small for register map");
   end
endmodule

`default_nettype wire

// >>> dce_trigger_match.sv
/*
 Compares an incoming interrupt event number against the start and abort
 selections every clock and resolves a same-cycle clash.
 Assumes at most one event number is presented per clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dce_trigger_match
#(
   parameter int IRQ_W = 8
)
(
   // Event input
   input wire logic event_valid,
   input wire logic [IRQ_W-1:0] event_num,
   // Selections and enables
   input wire logic [IRQ_W-1:0] start_sel,
   input wire logic [IRQ_W-1:0] abort_sel,
   input wire logic start_en,
   input wire logic abort_en,
   // Results
   output logic start_hit,
   output logic abort_hit
);
   // ----------------------------------------
   // Compare
   // ----------------------------------------
   wire logic start_eq = event_valid & (event_num == start_sel);
   wire logic abort_eq = event_valid & (event_num == abort_sel);

   // Enabled matches, abort beats start
   assign abort_hit = abort_en & abort_eq;
   assign start_hit = start_en & start_eq & ~abort_hit;

   // Elaboration check on event width
   if (IRQ_W < 1 || IRQ_W > 8) begin : g_bad_irq
      $error("dce_trigger_match: IRQ_W must be 1 to 8");
   end
endmodule

`default_nettype wire

// >>> dce_channel.sv
/*
 DMA channel event control: event control, source size and destination
 size registers, start and abort triggering from interrupt numbers,
 forced start, software abort and pattern-match abort.
 Assumes interrupt events and engine signals are synchronous to clock.
*/
`include "dce_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dce_channel
#(
   parameter int ADDR_W = 12,
   parameter int IRQ_W = 8,
   parameter int SIZE_W = 16
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output var logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt event lines
   input wire logic irq_event_valid,
   input wire logic [IRQ_W-1:0] irq_event_num,
   // Transfer engine
   input wire logic pattern_match,
   input wire logic xfer_done,
   output var logic start_cell,
   output var logic abort_xfer,
   output var logic xfer_active,
   output var logic [SIZE_W-1:0] source_byte_count,
   output var logic [SIZE_W-1:0] destination_byte_count,
   // Channel status
   output var logic channel_on,
   output var logic abort_interrupt_flag
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   dce_pkg::dce_state_t state;
   dce_pkg::dce_state_t next_state;
   dce_pkg::dce_reg_t reg_sel;
   logic write_strobe;
   logic [31:0] read_word;
   logic [IRQ_W-1:0] start_irq_select;
   logic [IRQ_W-1:0] abort_irq_select;
   logic pattern_abort_enable;
   logic start_trigger_enable;
   logic abort_trigger_enable;
   logic start_hit;
   logic abort_hit;

   // ----------------------------------------
   // Bus front end
   // ----------------------------------------
   dce_apb_slave #(.ADDR_W(ADDR_W)) u_apb
   (
      .clock(clock),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .read_word(read_word),
      .reg_sel(reg_sel),
      .write_strobe(write_strobe)
   );

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   wire logic wr_ctrl = write_strobe & (reg_sel == dce_pkg::DCE_REG_CTRL);
   wire logic wr_stat = write_strobe & (reg_sel == dce_pkg::DCE_REG_STAT);
   wire logic wr_econ = write_strobe & (reg_sel == dce_pkg::DCE_REG_ECON);
   wire logic wr_ssiz = write_strobe & (reg_sel == dce_pkg::DCE_REG_SSIZ);
   wire logic wr_dsiz = write_strobe & (reg_sel == dce_pkg::DCE_REG_DSIZ);

   // Self-clearing command bits, act only in the write cycle
   wire logic force_transfer = wr_econ & pwdata[`DCE_FORCE_BIT];
   wire logic software_abort = wr_econ & pwdata[`DCE_SWABORT_BIT];

   // Clear of the abort flag, write one to clear
   wire logic aflag_clear = wr_stat & pwdata[`DCE_AFLAG_BIT];

   // ----------------------------------------
   // Trigger matching
   // ----------------------------------------
   dce_trigger_match #(.IRQ_W(IRQ_W)) u_match
   (
      .event_valid(irq_event_valid),
      .event_num(irq_event_num),
      .start_sel(start_irq_select),
      .abort_sel(abort_irq_select),
      .start_en(start_trigger_enable),
      .abort_en(abort_trigger_enable),
      .start_hit(start_hit),
      .abort_hit(abort_hit)
   );

   // ----------------------------------------
   // Event resolution
   // ----------------------------------------
   // Interrupt triggers only act on an enabled channel
   wire logic irq_abort = channel_on & abort_hit;
   wire logic irq_start = channel_on & start_hit;

   // Pattern match acts only when its enable is set
   wire logic pat_abort = pattern_abort_enable & pattern_match;

   // Any abort source
   wire logic any_abort = irq_abort | software_abort | pat_abort;

   // Start sources, suppressed by any abort in the same cycle
   wire logic any_start = (irq_start | force_transfer) & ~any_abort;

   // ----------------------------------------
   // Transfer state
   // ----------------------------------------
   // Next state of the channel transfer
   always_comb
   begin
      next_state = state;
      unique case (state)
         dce_pkg::DCE_IDLE:
         begin
            if (any_start)
               next_state = dce_pkg::DCE_ACTIVE;
         end
         dce_pkg::DCE_ACTIVE:
         begin
            if (any_abort)
               next_state = dce_pkg::DCE_IDLE;
            else if (xfer_done & ~any_start)
               next_state = dce_pkg::DCE_IDLE;
         end
         default:
            next_state = dce_pkg::DCE_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         state <= dce_pkg::DCE_IDLE;
      else
         state <= next_state;
   end

   assign xfer_active = (state == dce_pkg::DCE_ACTIVE);

   // ----------------------------------------
   // Engine command pulses
   // ----------------------------------------
   // One-cycle start and abort requests to the engine
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         start_cell <= 1'b0;
         abort_xfer <= 1'b0;
      end
      else
      begin
         start_cell <= any_start;
         abort_xfer <= any_abort & xfer_active;
      end
   end

   // ----------------------------------------
   // Channel on and abort flag
   // ----------------------------------------
   // Pattern abort clears channel on, over a software write
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         channel_on <= 1'b0;
      else if (pat_abort)
         channel_on <= 1'b0;
      else if (wr_ctrl)
         channel_on <= pwdata[`DCE_CHON_BIT];
   end

   // Abort flag, set beats clear
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         abort_interrupt_flag <= 1'b0;
      else if (irq_abort)
         abort_interrupt_flag <= 1'b1;
      else if (aflag_clear)
         abort_interrupt_flag <= 1'b0;
   end

   // ----------------------------------------
   // Event control fields
   // ----------------------------------------
   // Selections reset to all ones
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         start_irq_select <= IRQ_W'(`DCE_SEL_RESET);
         abort_irq_select <= IRQ_W'(`DCE_SEL_RESET);
      end
      else if (wr_econ)
      begin
         start_irq_select <= pwdata[`DCE_START_SEL_LO +: IRQ_W];
         abort_irq_select <= pwdata[`DCE_ABORT_SEL_LO +: IRQ_W];
      end
   end

   // Enable bits
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pattern_abort_enable <= 1'b0;
         start_trigger_enable <= 1'b0;
         abort_trigger_enable <= 1'b0;
      end
      else if (wr_econ)
      begin
         pattern_abort_enable <= pwdata[`DCE_PATTERN_ABORT_ENABLE_BIT];
         start_trigger_enable <= pwdata[`DCE_STARTEN_BIT];
         abort_trigger_enable <= pwdata[`DCE_ABORTEN_BIT];
      end
   end

   // ----------------------------------------
   // Size registers
   // ----------------------------------------
   // Source and destination byte counts
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         source_byte_count <= SIZE_W'(`DCE_SIZE_RESET);
         destination_byte_count <= SIZE_W'(`DCE_SIZE_RESET);
      end
      else
      begin
         if (wr_ssiz)
            source_byte_count <= pwdata[SIZE_W-1:0];
         if (wr_dsiz)
            destination_byte_count <= pwdata[SIZE_W-1:0];
      end
   end

   // ----------------------------------------
   // Read back
   // ----------------------------------------
   // Event control image; command bits and unused bits read zero
   logic [31:0] econ_word;
   always_comb
   begin
      econ_word = `DCE_ZERO32;
      econ_word[`DCE_ABORT_SEL_LO +: IRQ_W] = abort_irq_select;
      econ_word[`DCE_START_SEL_LO +: IRQ_W] = start_irq_select;
      econ_word[`DCE_PATTERN_ABORT_ENABLE_BIT] = pattern_abort_enable;
      econ_word[`DCE_STARTEN_BIT] = start_trigger_enable;
      econ_word[`DCE_ABORTEN_BIT] = abort_trigger_enable;
   end

   // Control and status images
   logic [31:0] ctrl_word;
   logic [31:0] stat_word;
   always_comb
   begin
      ctrl_word = `DCE_ZERO32;
      ctrl_word[`DCE_CHON_BIT] = channel_on;
      ctrl_word[`DCE_ACTIVE_BIT] = xfer_active;
      stat_word = `DCE_ZERO32;
      stat_word[`DCE_AFLAG_BIT] = abort_interrupt_flag;
   end

   // Size images, upper half zero
   wire logic [31:0] ssiz_word = {{(32-SIZE_W){1'b0}}, source_byte_count};
   wire logic [31:0] dsiz_word = {{(32-SIZE_W){1'b0}}, destination_byte_count};

   // Read selection
   assign read_word =
      (reg_sel == dce_pkg::DCE_REG_CTRL) ? ctrl_word :
      (reg_sel == dce_pkg::DCE_REG_STAT) ? stat_word :
      (reg_sel == dce_pkg::DCE_REG_ECON) ? econ_word :
      (reg_sel == dce_pkg::DCE_REG_SSIZ) ? ssiz_word :
      (reg_sel == dce_pkg::DCE_REG_DSIZ) ? dsiz_word :
      `DCE_ZERO32;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (IRQ_W != 8) begin : g_bad_irq
      $error("dce_channel: selection fields are 8 bits wide");
   end
   if (SIZE_W != 16) begin : g_bad_size
      $error("dce_channel: size fields are 16 bits wide");
   end
endmodule

`default_nettype wire

// >>> dce_engine_model.sv
/*
 Transfer engine model facing the channel: runs a cell, ends it with a done pulse.
 Assumes start and abort pulses synchronous to clock; stall holds a cell open.
*/
`timescale 1ns/1ps
`default_nettype none

module dce_engine_model
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Channel side and bench controls
   input wire logic start_cell,
   input wire logic abort_xfer,
   input wire logic stall,
   input wire logic match_req,
   output logic xfer_done,
   output logic pattern_match
);
   logic busy;

   // Done when not stalled; a pattern only matches while data moves
   assign xfer_done = busy && !stall;
   assign pattern_match = match_req && busy;

   // Busy from a start until done or abort
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         busy <= 1'h0;
      end
      else
      begin
         busy <= !abort_xfer && (start_cell || (busy && stall));
      end
   end
endmodule

`default_nettype wire

// >>> dce_channel_sva.sv
/*
 Checker for the channel event control block, bound to dce_channel.
 Assumes default widths: 12-bit byte address, 8-bit interrupt numbers.
*/
`include "dce_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dce_channel_sva
(
   // Clock, reset and APB
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // Events and engine
   input wire logic irq_event_valid,
   input wire logic [7:0] irq_event_num,
   input wire logic pattern_match,
   input wire logic start_cell,
   input wire logic abort_xfer,
   input wire logic xfer_active,
   input wire logic channel_on,
   input wire logic abort_interrupt_flag
);
   // ------------------------------
   // Shadow of event control word
   // ------------------------------
   logic [31:0] econ;
   wire wr = psel && penable && pwrite;
   wire rd = psel && penable && !pwrite;
   wire wr_econ = wr && paddr == `DCE_OFS_ECON;
   wire s_hit = irq_event_valid && irq_event_num == econ[15:8];
   wire a_num = irq_event_valid && irq_event_num == econ[23:16];
   wire a_hit = a_num && econ[3] && channel_on;

   // Follows every accepted write to the event control offset
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         econ <= `DCE_ECON_RESET;
      end
      else if (wr_econ)
      begin
         econ <= pwdata;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // ------------------------------
   // Properties
   // ------------------------------
   irq_start_a: assert property (
      s_hit && econ[4] && channel_on && !a_hit && !(pattern_match && econ[5]) && !wr
      |=> start_cell && xfer_active) else $error("irq start missed");
   no_start_a: assert property (
      s_hit && !econ[4] && !wr |=> !start_cell) else $error("disabled start fired");
   irq_abort_a: assert property (
      a_hit |=> abort_interrupt_flag && !xfer_active && !start_cell
      && abort_xfer == $past(xfer_active)) else $error("irq abort wrong");
   no_abort_a: assert property (
      a_num && !econ[3] && !pattern_match && !wr |=> !abort_xfer) else $error("disabled abort");
   force_start_a: assert property (
      wr_econ && pwdata[7] && !pwdata[6] && !irq_event_valid && !pattern_match
      |=> start_cell && xfer_active) else $error("force start missed");
   sw_abort_a: assert property (
      wr_econ && pwdata[6] |=> !xfer_active && !start_cell
      && abort_xfer == $past(xfer_active)) else $error("software abort wrong");
   pattern_abort_a: assert property (
      pattern_match && econ[5] |=> !channel_on && !xfer_active
      && abort_xfer == $past(xfer_active)) else $error("pattern abort wrong");
   pattern_off_a: assert property (
      pattern_match && !econ[5] && !wr && !irq_event_valid
      |=> $stable(channel_on) && !abort_xfer) else $error("pattern acted while off");
   econ_read_a: assert property (
      rd && paddr == `DCE_OFS_ECON |-> prdata[31:24] == 8'h00 && prdata[7:6] == 2'h0
      && prdata[2:0] == 3'h0) else $error("event control spare bits set");
   size_read_a: assert property (
      rd && (paddr == `DCE_OFS_SSIZ || paddr == `DCE_OFS_DSIZ) |-> prdata[31:16] == 16'h0000)
      else $error("size upper half set");
endmodule

bind dce_channel dce_channel_sva dce_channel_sva_inst (.clock, .rst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .irq_event_valid, .irq_event_num, .pattern_match, .start_cell,
   .abort_xfer, .xfer_active, .channel_on, .abort_interrupt_flag);

`default_nettype wire

// >>> tb_top.sv
/*
 Self-checking bench for the channel event control block.
 Assumes the engine model on the far side and the bound checker.
*/
`include "dce_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic clock, rst, pready, pslverr, xfer_done, start_cell, abort_xfer, xfer_active, err;
   logic pattern_match, channel_on, abort_interrupt_flag;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, irq_event_valid = 1'h0;
   logic stall = 1'h0, match_req = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0] irq_event_num = 8'h00;
   logic [15:0] source_byte_count, destination_byte_count;
   int n_mismatch = 0;
   int check_count = 0;

   // ------------------------------
   // Channel and engine model
   // ------------------------------
   dce_channel dce_channel_inst (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .irq_event_valid, .irq_event_num, .pattern_match,
      .xfer_done, .start_cell, .abort_xfer, .xfer_active, .source_byte_count,
      .destination_byte_count, .channel_on, .abort_interrupt_flag);
   dce_engine_model dce_engine_model_inst (.clock, .rst, .start_cell, .abort_xfer, .stall,
      .match_req, .xfer_done, .pattern_match);

   // 50 MHz clock
   initial
   begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end

   // Word and flag comparisons
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic flag(input string what, input logic exp, input logic got);
      check(what, {31'h0, exp}, {31'h0, got});
   endtask

   // One APB transfer; returns just after its sampling edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      i = 0;
      do
      begin
         @(posedge clock);
         i++;
      end
      while (pready !== 1'h1 && i < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      #1;
      if (pready !== 1'h1)
      begin
         n_mismatch++;
         end_sim();
      end
   endtask

   // One-cycle interrupt event or pattern match
   task automatic ev(input logic pat, input logic [7:0] n);
      @(posedge clock);
      irq_event_valid <= !pat;
      match_req <= pat;
      irq_event_num <= n;
      @(posedge clock);
      irq_event_valid <= 1'h0;
      match_req <= 1'h0;
      #1;
   endtask

   task automatic t_regs();
      apb(1'h0, `DCE_OFS_ECON, 32'h0);
      check("econ reset", `DCE_ECON_RESET, rd);
      apb(1'h0, `DCE_OFS_DSIZ, 32'h0);
      check("dsiz reset", 32'h0, rd);
      apb(1'h1, `DCE_OFS_SSIZ, 32'hFFFF_FFFF);
      apb(1'h1, `DCE_OFS_DSIZ, 32'h1234_ABCD);
      apb(1'h0, `DCE_OFS_SSIZ, 32'h0);
      check("ssiz out", 32'h0000_FFFF, {16'h0000, source_byte_count});
      check("ssiz max", 32'h0000_FFFF, rd);
      apb(1'h0, `DCE_OFS_DSIZ, 32'h0);
      check("dsiz", 32'h0000_ABCD, {16'h0000, destination_byte_count});
      check("dsiz read", 32'h0000_ABCD, rd);
      apb(1'h1, `DCE_OFS_ECON, 32'hFFFF_FF38);
      apb(1'h0, `DCE_OFS_ECON, 32'h0);
      check("econ spare", 32'h00FF_FF38, rd);
      apb(1'h0, 12'h020, 32'h0);
      flag("unmapped", 1'h1, err);
      check("unmapped read", 32'h0, rd);
      $display("test regs done");
   endtask

   task automatic t_force();
      apb(1'h1, `DCE_OFS_ECON, 32'h0000_0080);
      flag("force start", 1'h1, start_cell);
      flag("force active", 1'h1, xfer_active);
      apb(1'h0, `DCE_OFS_ECON, 32'h0);
      check("force reads", 32'h0, rd);
      flag("done idle", 1'h0, xfer_active);
      stall <= 1'h1;
      apb(1'h1, `DCE_OFS_ECON, 32'h0000_0080);
      apb(1'h1, `DCE_OFS_ECON, 32'h0000_0040);
      flag("sw abort", 1'h1, abort_xfer);
      flag("sw idle", 1'h0, xfer_active);
      apb(1'h0, `DCE_OFS_ECON, 32'h0);
      check("abort reads", 32'h0, rd);
      $display("test force done");
   endtask

   task automatic t_irq();
      logic [7:0] c;
      apb(1'h1, `DCE_OFS_CTRL, 32'h1);
      apb(1'h0, `DCE_OFS_CTRL, 32'h0);
      check("ctrl on", 32'h0000_0001, rd);
      for (int k = 0; k < 3; k++)
      begin
         c = (k == 0) ? 8'h00 : (k == 1) ? 8'h5A : 8'hFF;
         apb(1'h1, `DCE_OFS_ECON, {8'h00, ~c, c, 8'h18});
         ev(1'h0, c);
         flag("irq start", 1'h1, start_cell);
         apb(1'h0, `DCE_OFS_CTRL, 32'h0);
         check("ctrl active", 32'h0000_0003, rd);
         ev(1'h0, ~c);
         flag("irq abort", 1'h1, abort_xfer);
         flag("abort idle", 1'h0, xfer_active);
         flag("abort flag", 1'h1, abort_interrupt_flag);
         apb(1'h0, `DCE_OFS_STAT, 32'h0);
         check("stat flag", 32'h0000_0001, rd);
         apb(1'h1, `DCE_OFS_STAT, 32'h1);
         flag("flag clear", 1'h0, abort_interrupt_flag);
      end
      $display("test irq done");
   endtask

   task automatic t_off();
      apb(1'h1, `DCE_OFS_ECON, 32'h0022_1100);
      ev(1'h0, 8'h11);
      flag("start off", 1'h0, start_cell);
      apb(1'h1, `DCE_OFS_ECON, 32'h0022_1180);
      ev(1'h0, 8'h22);
      flag("abort off", 1'h0, abort_xfer);
      flag("kept active", 1'h1, xfer_active);
      apb(1'h1, `DCE_OFS_ECON, 32'h0033_3398);
      ev(1'h0, 8'h33);
      flag("clash start", 1'h0, start_cell);
      flag("clash abort", 1'h1, abort_xfer);
      $display("test off and clash done");
   endtask

   task automatic t_pattern();
      apb(1'h1, `DCE_OFS_ECON, 32'h0000_0080);
      ev(1'h1, 8'h00);
      flag("pattern ignored", 1'h1, channel_on);
      flag("pattern kept", 1'h1, xfer_active);
      apb(1'h1, `DCE_OFS_ECON, 32'h0000_00A0);
      ev(1'h1, 8'h00);
      flag("pattern abort", 1'h1, abort_xfer);
      flag("pattern chan off", 1'h0, channel_on);
      $display("test pattern done");
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Reset, then the scenarios
   initial
   begin
      rst = 1'h1;
      repeat (12) @(posedge clock);
      rst <= 1'h0;
      t_regs();
      t_force();
      t_irq();
      t_off();
      t_pattern();
      end_sim();
   end
endmodule

`default_nettype wire
